// ===== core/ocp_ctrl.sv
/*
 * ocp_ctrl: control of the four optional configuration pins (start-up clock,
 * open-drain init-complete, global output enable, global register clear).
 * assumes option bits arrive from the configuration loader with a load strobe,
 * and the pins come from outside the clock domain.
 */
`timescale 1ns/10ps
// Behaviour
// - with its option on, the start-up clock pin times initialization, otherwise it is user I/O.
// - in active serial mode the serial config clock may be made from the start-up clock pin.
// - while config restart is low the init-complete pin is not driven.
// - init-complete is pulled low once its option bit has been loaded from the first frame.
// - init-complete is released when initialization ends, together with entry to user mode.
// - with calibration gating on, the release waits for termination calibration to complete.
// - with its option on, a low global output enable tri-states every user I/O.
// - with its option on, a low global register clear clears every device register.
// - any optional pin whose option is off is ordinary user I/O.
// - during configuration, unused optional pins are tri-stated with weak pull-ups.
module ocp_ctrl
    import ocp_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 config_restart_n_i,
    input  wire logic                 frame_opts_valid_i,
    input  wire logic                 opt_startup_clock_i,
    input  wire logic                 opt_init_done_i,
    input  wire logic                 opt_cal_gate_i,
    input  wire logic                 opt_global_oe_i,
    input  wire logic                 opt_global_clr_i,
    input  wire logic                 opt_clk_src_user_i,
    input  wire logic                 active_serial_scheme_i,
    input  wire logic                 config_data_done_i,
    input  wire logic                 termination_cal_complete_i,
    input  wire logic                 user_startup_clock_i,
    input  wire logic                 global_output_enable_i,
    input  wire logic                 global_register_clear_n_i,
    input  wire logic [USER_IO_W-1:0] core_io_oe_i,
    input  wire logic [USER_IO_W-1:0] core_io_out_i,
    input  wire logic                 int_osc_tick_i,
    output logic                      init_done_out_o,
    output logic                      init_done_oe_o,
    output logic                      user_mode_o,
    output logic                      serial_config_clock_tick_o,
    output logic [USER_IO_W-1:0]      io_oe_o,
    output logic [USER_IO_W-1:0]      io_out_o,
    output logic [USER_IO_W-1:0]      io_pull_o,
    output logic                      core_reg_clear_o
);
    ocp_state_t state_r;
    ocp_state_t state_nxt;
    logic       restart_n_s;
    logic       uclk_s;
    logic       goe_s;
    logic       gclr_n_s;
    logic       cal_s;
    logic       uclk_d_r;
    logic       uclk_rise;
    logic       init_tick;
    logic [7:0] init_cnt_r;
    logic       opt_init_r;
    logic       opt_uclk_r;
    logic       opt_cal_r;
    logic       opt_goe_r;
    logic       opt_gclr_r;
    logic       opt_src_r;

    // restart held asserted until synced, else the machine visits load right after reset
    ocp_sync #(.RST_VAL(SYNC_RST_LO)) u_sync_rst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .async_i(config_restart_n_i), .sync_o(restart_n_s));
    // low to match uclk_d_r, so reset makes no false start-up clock edge
    ocp_sync #(.RST_VAL(SYNC_RST_LO)) u_sync_uclk (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .async_i(user_startup_clock_i), .sync_o(uclk_s));
    ocp_sync #(.RST_VAL(SYNC_RST_HI)) u_sync_goe (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .async_i(global_output_enable_i), .sync_o(goe_s));
    ocp_sync #(.RST_VAL(SYNC_RST_HI)) u_sync_gclr (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .async_i(global_register_clear_n_i), .sync_o(gclr_n_s));
    ocp_sync #(.RST_VAL(SYNC_RST_LO)) u_sync_cal (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .async_i(termination_cal_complete_i), .sync_o(cal_s));

    // the pin clock is sampled, so it must be well below half of clk_sys_i
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            uclk_d_r <= 1'b0;
        end else begin
            uclk_d_r <= uclk_s;
        end
    end
    assign uclk_rise = uclk_s & ~uclk_d_r;
    assign init_tick = opt_uclk_r ? uclk_rise : int_osc_tick_i;

    // option bits latched from the first frame; cleared by a restart
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            opt_init_r <= 1'b0;
            opt_uclk_r <= 1'b0;
            opt_cal_r  <= 1'b0;
            opt_goe_r  <= 1'b0;
            opt_gclr_r <= 1'b0;
            opt_src_r  <= 1'b0;
        end else if (!restart_n_s) begin
            opt_init_r <= 1'b0;
            opt_uclk_r <= 1'b0;
            opt_cal_r  <= 1'b0;
            opt_goe_r  <= 1'b0;
            opt_gclr_r <= 1'b0;
            opt_src_r  <= 1'b0;
        end else if (state_r == OCP_LOAD_OPT && frame_opts_valid_i) begin
            opt_init_r <= opt_init_done_i;
            opt_uclk_r <= opt_startup_clock_i;
            opt_cal_r  <= opt_cal_gate_i;
            opt_goe_r  <= opt_global_oe_i;
            opt_gclr_r <= opt_global_clr_i;
            opt_src_r  <= opt_clk_src_user_i & active_serial_scheme_i;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            OCP_RESTART:  if (restart_n_s) state_nxt = OCP_LOAD_OPT;
            OCP_LOAD_OPT: if (frame_opts_valid_i) state_nxt = OCP_CONFIG;
            OCP_CONFIG:   if (config_data_done_i) state_nxt = OCP_INIT;
            OCP_INIT:     if (init_tick && init_cnt_r == INIT_TICKS) begin
                              state_nxt = (opt_cal_r && !cal_s) ? OCP_WAIT_CAL
                                                                : OCP_USER;
                          end
            OCP_WAIT_CAL: if (cal_s) state_nxt = OCP_USER;
            OCP_USER:     state_nxt = OCP_USER;
            default:      state_nxt = OCP_RESTART;
        endcase
        if (!restart_n_s) state_nxt = OCP_RESTART;
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= OCP_RESTART;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_cnt_r <= 8'h00;
        end else if (state_r != OCP_INIT) begin
            init_cnt_r <= 8'h00;
        end else if (init_tick && init_cnt_r != INIT_TICKS) begin
            init_cnt_r <= init_cnt_r + 8'h01;
        end
    end

    // open drain: the value stays zero, only the enable moves
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            init_done_out_o <= 1'b0;
            init_done_oe_o  <= INIT_DONE_RST;
            user_mode_o     <= 1'b0;
        end else begin
            init_done_out_o <= 1'b0;
            init_done_oe_o  <= restart_n_s && opt_init_r && state_nxt != OCP_USER
                               && state_nxt != OCP_RESTART;
            user_mode_o     <= state_nxt == OCP_USER;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_config_clock_tick_o <= 1'b0;
        end else begin
            serial_config_clock_tick_o <= opt_src_r ? uclk_rise : int_osc_tick_i;
        end
    end

    // before user mode every user pin floats with pull-ups
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            io_oe_o   <= IO_OE_RST;
            io_out_o  <= IO_OUT_RST;
            io_pull_o <= IO_PULL_RST;
        end else if (state_nxt != OCP_USER) begin
            io_oe_o   <= IO_OE_RST;
            io_out_o  <= IO_OUT_RST;
            io_pull_o <= IO_PULL_RST;
        end else begin
            io_oe_o   <= (opt_goe_r && !goe_s) ? IO_OE_RST : core_io_oe_i;
            io_out_o  <= core_io_out_i;
            io_pull_o <= IO_OUT_RST;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            core_reg_clear_o <= 1'b0;
        end else begin
            core_reg_clear_o <= opt_gclr_r && !gclr_n_s;
        end
    end

    init_low_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_r == OCP_CONFIG && opt_init_r && restart_n_s) |=> init_done_oe_o)
        else $error("init-complete not pulled low after option load");
    restart_float_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !restart_n_s |=> !init_done_oe_o)
        else $error("init-complete driven during restart");
    od_value_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        init_done_oe_o |-> init_done_out_o == 1'b0)
        else $error("init-complete driven high");
    release_user_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(user_mode_o) && opt_init_r |-> $fell(init_done_oe_o))
        else $error("release not aligned with user mode");
    cal_gate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_r == OCP_WAIT_CAL && !cal_s) |=> !user_mode_o)
        else $error("user mode before calibration done");
    goe_tri_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (opt_goe_r && !goe_s) |=> io_oe_o == IO_OE_RST)
        else $error("outputs driven under global disable");
    gclr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (opt_gclr_r && !gclr_n_s) |=> core_reg_clear_o)
        else $error("registers not cleared");
    gclr_off_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !opt_gclr_r |=> !core_reg_clear_o)
        else $error("clear acted with option off");
    cfg_pull_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_r == OCP_CONFIG) |=> io_pull_o == IO_PULL_RST && io_oe_o == IO_OE_RST)
        else $error("user pins not floating in configuration");
    src_sel_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (!opt_src_r && int_osc_tick_i) |=> serial_config_clock_tick_o)
        else $error("serial clock tick lost");
endmodule : ocp_ctrl

// ===== core/ocp_pkg.sv
/*
 * ocp_pkg: constants and types for the optional configuration pin control.
 * assumes one 100 MHz system clock and an active-low asynchronous reset.
 */
package ocp_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    // user-pin count the override acts on
    localparam int unsigned USER_IO_W      = 8;
    // synchroniser reset levels: restart reads asserted, calibration not done
    localparam logic        SYNC_RST_LO    = 1'b0;
    localparam logic        SYNC_RST_HI    = 1'b1;
    localparam logic [USER_IO_W-1:0] IO_OE_RST   = 8'h00;
    localparam logic [USER_IO_W-1:0] IO_OUT_RST  = 8'h00;
    localparam logic [USER_IO_W-1:0] IO_PULL_RST = 8'hff;
    // internal init sequence length counted in init_tick pulses (start-up clock pin edges or internal oscillator ticks)
    localparam logic [7:0]  INIT_TICKS     = 8'h10;
    localparam logic        INIT_DONE_RST  = 1'b0;
    typedef enum logic [2:0] {
        OCP_RESTART,
        OCP_LOAD_OPT,
        OCP_CONFIG,
        OCP_INIT,
        OCP_WAIT_CAL,
        OCP_USER
    } ocp_state_t;
endpackage : ocp_pkg

// ===== core/ocp_sync.sv
/*
 * ocp_sync: two-flop synchroniser for a pin level.
 * assumes the input is asynchronous to clk_sys_i.
 */
`timescale 1ns/10ps
module ocp_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_sys_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_r;
    // reset level per instance, so a pin reads as its safe level until synced
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : ocp_sync

// ===== verif/ocp_host_mon.sv
/*
 * ocp_host_mon: outside monitor watching the open-drain init-complete pin.
 * assumes a pull-up on the pin and sampling on the system clock.
 */
`timescale 1ns/10ps
module ocp_host_mon (
    input  wire logic        clk_sys_i,
    input  wire logic        init_done_oe_i,
    input  wire logic        init_done_out_i,
    output logic             pin_level_o,
    output logic [7:0]       rise_cnt_o
);
    logic pin_q;
    // undriven pin floats high through the pull-up
    assign pin_level_o = init_done_oe_i ? init_done_out_i : 1'b1;
    initial rise_cnt_o = 8'h00;
    initial pin_q = 1'b1;
    always @(posedge clk_sys_i) begin
        if (pin_level_o && !pin_q) begin
            rise_cnt_o <= rise_cnt_o + 8'h01;
        end
        pin_q <= pin_level_o;
    end
endmodule : ocp_host_mon

// ===== verif/ocp_ctrl_tb.sv
/*
 * ocp_ctrl_tb: directed checks of the optional configuration pin control.
 * assumes a 100 MHz clock; inputs move on the falling edge.
 */
`timescale 1ns/10ps
module ocp_ctrl_tb;
    logic       clk_sys_i, reset_n_i, restart_n, opts_vld, as_sel, data_done, cal_ok;
    logic       uclk, osc_tick, goe, gclr_n, done_out, done_oe, umode, sck, rclr, pin, hit;
    logic [5:0] opts;
    logic [7:0] c_oe, c_out, io_oe, io_out, io_pull, rises;
    int         errors, checks, nsck;

    ocp_ctrl u_ocp_ctrl (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .config_restart_n_i(restart_n), .frame_opts_valid_i(opts_vld),
        .opt_startup_clock_i(opts[1]), .opt_init_done_i(opts[0]), .opt_cal_gate_i(opts[2]),
        .opt_global_oe_i(opts[3]), .opt_global_clr_i(opts[4]), .opt_clk_src_user_i(opts[5]),
        .active_serial_scheme_i(as_sel), .config_data_done_i(data_done),
        .termination_cal_complete_i(cal_ok), .user_startup_clock_i(uclk),
        .global_output_enable_i(goe), .global_register_clear_n_i(gclr_n),
        .core_io_oe_i(c_oe), .core_io_out_i(c_out), .int_osc_tick_i(osc_tick),
        .init_done_out_o(done_out), .init_done_oe_o(done_oe), .user_mode_o(umode),
        .serial_config_clock_tick_o(sck), .io_oe_o(io_oe), .io_out_o(io_out),
        .io_pull_o(io_pull), .core_reg_clear_o(rclr));
    ocp_host_mon u_ocp_host_mon (.clk_sys_i(clk_sys_i), .init_done_oe_i(done_oe),
        .init_done_out_i(done_out), .pin_level_o(pin), .rise_cnt_o(rises));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("counts: checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    // restart, then hand in the first-frame option bits
    task automatic cfg(input logic [5:0] o);
        restart_n = 1'b0;
        data_done = 1'b0;
        cyc(4);
        chk("init_oe_restart", 8'h00, {7'h0, done_oe});
        chk("init_pin_restart", 8'h01, {7'h0, pin});
        restart_n = 1'b1;
        opts = o;
        cyc(4);
        opts_vld = 1'b1;
        cyc(3);
        opts_vld = 1'b0;
        cyc(1);
        chk("init_oe_loaded", {7'h0, o[0]}, {7'h0, done_oe});
        chk("pull_cfg", 8'hff, io_pull);
        data_done = 1'b1;
    endtask : cfg

    // tick the internal source, and the start-up pin when tog_u is set, until user mode, bounded
    task automatic run(input int max, input logic tog_u, input logic need);
        hit = 1'b0;
        nsck = 0;
        for (int i = 0; i < max && !hit; i++) begin
            if (tog_u) uclk = ~uclk;
            osc_tick = ~osc_tick;
            cyc(1);
            nsck += int'(sck === 1'b1);
            if (umode === 1'b1) begin
                hit = 1'b1;
                chk("init_oe_user", 8'h00, {7'h0, done_oe});
            end
        end
        if (need && !hit) begin
            errors++;
            $display("[ERR] user_mode_wait expected 1 seen 0");
            close_out();
        end
    endtask : run

    initial begin
        {reset_n_i, restart_n, opts_vld, data_done, uclk, osc_tick} = 6'h00;
        {as_sel, cal_ok, goe, gclr_n} = 4'hf;
        opts = 6'h00;
        c_oe = 8'hff;
        c_out = 8'ha5;
        errors = 0;
        checks = 0;
        repeat (20) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        cyc(3);
        chk("pull_rst", 8'hff, io_pull);
        chk("out_rst", 8'h00, {7'h0, done_out});
        $display("test reset done");
        cfg(6'h23);
        run(400, 1'b1, 1'b1);
        // the monitor sees the pin rise one edge after the release
        cyc(1);
        chk("user_mode", 8'h01, {7'h0, umode});
        chk("rise_seen", 8'h01, rises);
        chk("sck_seen", 8'h01, {7'h0, nsck > 0});
        chk("out_user", 8'h00, {7'h0, done_out});
        $display("test startup done");
        cal_ok = 1'b0;
        cfg(6'h07);
        // start-up clock option on but pin idle: the internal tick must not time init
        run(200, 1'b0, 1'b0);
        chk("uclk_stall", 8'h00, {7'h0, umode});
        run(200, 1'b1, 1'b0);
        chk("gated", 8'h00, {7'h0, umode});
        chk("gated_oe", 8'h01, {7'h0, done_oe});
        cal_ok = 1'b1;
        // release follows calibration through the synchroniser only
        run(5, 1'b1, 1'b1);
        $display("test cal gate done");
        cfg(6'h1b);
        run(400, 1'b1, 1'b1);
        chk("io_oe_hi", 8'hff, io_oe);
        chk("io_out", 8'ha5, io_out);
        chk("pull_user", 8'h00, io_pull);
        goe = 1'b0;
        cyc(4);
        chk("io_oe_lo", 8'h00, io_oe);
        goe = 1'b1;
        gclr_n = 1'b0;
        cyc(4);
        chk("clr_on", 8'h01, {7'h0, rclr});
        gclr_n = 1'b1;
        cyc(4);
        chk("clr_off", 8'h00, {7'h0, rclr});
        $display("test overrides done");
        // only the clock-source option on, start-up pin idle: no serial clock ticks
        cfg(6'h20);
        run(400, 1'b0, 1'b1);
        chk("sck_quiet", 8'h00, {7'h0, nsck > 0});
        goe = 1'b0;
        gclr_n = 1'b0;
        cyc(4);
        chk("plain_oe", 8'hff, io_oe);
        chk("plain_clr", 8'h00, {7'h0, rclr});
        chk("plain_init", 8'h00, {7'h0, done_oe});
        $display("test options off done");
        close_out();
    end
endmodule : ocp_ctrl_tb
